// file: common/scpm_pkg.sv
// Purpose: Shared constants and types for the serial config port
// Assumes: 24-bit serial words, 16-bit config registers
// Notes:   AXI offsets are byte addresses
package scpm_pkg;
  // Serial word layout
  localparam int WORD_BITS = 24;
  localparam int ADDR_BITS = 8;
  localparam int DATA_BITS = 16;
  localparam logic [4:0] LAST_BIT    = 5'h17;
  localparam logic [4:0] ADDR_DONE   = 5'h08;
  localparam logic [4:0] ADDR_LAST   = 5'h07;
  // Config register addresses
  localparam logic [7:0] REG_CTRL0  = 8'h00;
  localparam logic [7:0] REG_CONV   = 8'h01;
  localparam logic [7:0] REG_ATTEN  = 8'hc5;
  localparam logic [7:0] REG_PATH   = 8'hc6;
  // Field positions
  localparam int READBACK_BIT    = 1;
  localparam int CONV_OFF_BIT    = 0;
  localparam int ATTEN_OFF_BIT   = 15;
  localparam int FAST_PD_BIT     = 14;
  localparam int AMP_OFF_BIT     = 12;
  localparam int POWER_MODE_LSB  = 10;
  localparam int CW_SELECT_BIT   = 9;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // Timing
  localparam int CLK_PERIOD_NS  = 50;
  localparam int PD_LIMIT_NS    = 1000;
  localparam int PD_LIMIT_CYC   = PD_LIMIT_NS / CLK_PERIOD_NS;
  // AXI4-Lite map
  localparam logic [7:0] AXI_STATUS    = 8'h00;
  localparam logic [7:0] AXI_WORDS     = 8'h04;
  localparam logic [7:0] AXI_PEEK_ADDR = 8'h08;
  localparam logic [7:0] AXI_PEEK_DATA = 8'h0c;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  typedef enum logic [0:0] {
    SP_IDLE  = 1'b0,
    SP_SHIFT = 1'b1
  } scpm_state_t;

  typedef struct packed {
    logic       atten_partial_off;
    logic       conv_partial_off;
    logic       atten_full_off;
    logic       conv_full_off;
    logic       refs_on;
    logic       serializers_on;
    logic       signal_amps_on;
    logic       atten_amp_off;
    logic       continuous_wave_en;
    logic       time_gain_en;
    logic [1:0] power_mode_field;
  } scpm_pwr_t;
endpackage

// file: hdl/scpm_sync.sv
// Purpose: Two-flop synchroniser bank
// Assumes: Inputs asynchronous to aclk
// Notes:   First stage feeds only the second
`timescale 1ns/1ps
module scpm_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             ce,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  initial
  begin
    if (WIDTH < 1) $error("scpm_sync: WIDTH must be positive");
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_r   <= '0;
      sync_out <= '0;
    end
    else if (ce)
    begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// file: hdl/scpm_edge.sv
// Purpose: Rise and fall detection on synchronised levels
// Assumes: Inputs already synchronised to aclk
// Notes:   Pulses last one aclk cycle
`timescale 1ns/1ps
module scpm_edge #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             ce,
  // Levels and pulses
  input  wire logic [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] prev_r;

  initial
  begin
    if (WIDTH < 1) $error("scpm_edge: WIDTH must be positive");
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      prev_r <= '0;
    else if (ce)
      prev_r <= level;
  end

  assign rise = level & ~prev_r & {WIDTH{ce}};
  assign fall = ~level & prev_r & {WIDTH{ce}};
endmodule

// file: hdl/scpm_port.sv
// Purpose: Serial config port with power-mode control and AXI4-Lite peek
// Assumes: Serial clock well below aclk/2, sampled as a plain input
// Notes:   Pins pass two flops, so edges are seen about two cycles late
`timescale 1ns/1ps
module scpm_port (
  // Clock, enable, reset
  input  wire logic              aclk,
  input  wire logic              ce,
  input  wire logic              aresetn,
  // Serial pins
  input  wire logic              serial_select_n,
  input  wire logic              serial_clk,
  input  wire logic              serial_data_in,
  output logic                   serial_data_out,
  output logic                   serial_data_out_oe,
  // Power pins and state
  input  wire logic              fast_powerdown_pin,
  input  wire logic              global_powerdown_pin,
  output scpm_pkg::scpm_pwr_t    pwr_state,
  // AXI4-Lite write
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  localparam int PD_BOUND = scpm_pkg::PD_LIMIT_CYC;

  logic [4:0]  pins_s;
  logic [1:0]  edge_rise;
  logic [1:0]  edge_fall;
  logic        sel_s;
  logic        sclk_s;
  logic        serial_data_in_s;
  logic        fast_s;
  logic        gbl_s;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        sel_fall;
  logic [15:0] regs_r [0:255];
  scpm_pkg::scpm_state_t state_r;
  logic [22:0] shreg_r;
  logic [4:0]  bitcnt_r;
  logic [15:0] rd_shift_r;
  logic [15:0] words_r;
  logic [7:0]  peek_addr_r;
  logic        shift_en;
  logic        word_done;
  logic        rb_load;
  logic        readback_en;
  logic        mem_we;
  logic [23:0] word;
  logic [7:0]  rb_addr;
  logic        aw_got_r;
  logic        w_got_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic        wstrb0_r;

  // Pins are asynchronous to aclk
  scpm_sync #(.WIDTH(5)) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    // Select enters inverted so the flop reset value is its idle level
    .async_in ({!serial_select_n, serial_clk, serial_data_in, fast_powerdown_pin, global_powerdown_pin}),
    .sync_out (pins_s)
  );

  assign sel_s  = !pins_s[4];
  assign sclk_s = pins_s[3];
  assign serial_data_in_s = pins_s[2];
  assign fast_s = pins_s[1];
  assign gbl_s  = pins_s[0];

  scpm_edge #(.WIDTH(2)) u_edge (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .level   ({pins_s[4], sclk_s}),
    .rise    (edge_rise),
    .fall    (edge_fall)
  );

  assign sclk_rise   = edge_rise[0];
  assign sclk_fall   = edge_fall[0];
  assign sel_fall    = edge_rise[1];
  assign readback_en = regs_r[scpm_pkg::REG_CTRL0][scpm_pkg::READBACK_BIT];
  assign shift_en    = sclk_rise && !sel_s;
  assign word        = {shreg_r, serial_data_in_s};
  assign word_done   = shift_en && (bitcnt_r == scpm_pkg::LAST_BIT);
  assign rb_load     = shift_en && (bitcnt_r == scpm_pkg::ADDR_LAST);
  assign rb_addr     = {shreg_r[6:0], serial_data_in_s};
  assign mem_we      = word_done && (!readback_en || word[23:16] == scpm_pkg::REG_CTRL0);

  // Frame state follows the select line
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_r <= scpm_pkg::SP_IDLE;
    else if (ce)
    begin
      case (state_r)
        scpm_pkg::SP_IDLE:  if (!sel_s) state_r <= scpm_pkg::SP_SHIFT;
        scpm_pkg::SP_SHIFT: if (sel_s) state_r <= scpm_pkg::SP_IDLE;
        default:            state_r <= scpm_pkg::SP_IDLE;
      endcase
    end
  end

  // Shift register and group counter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      shreg_r  <= '0;
      bitcnt_r <= '0;
    end
    else if (ce)
    begin
      if (sel_s || sel_fall)
        bitcnt_r <= '0;
      else if (shift_en)
      begin
        shreg_r  <= word[22:0];
        bitcnt_r <= (bitcnt_r == scpm_pkg::LAST_BIT) ? 5'h00 : bitcnt_r + 5'h01;
      end
    end
  end

  // Register store; partial words never reach it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < 256; i++)
        regs_r[i] <= scpm_pkg::REG_RESET;
    end
    else if (ce && mem_we)
    begin
      if (readback_en)
        regs_r[scpm_pkg::REG_CTRL0][scpm_pkg::READBACK_BIT] <= word[scpm_pkg::READBACK_BIT];
      else
        regs_r[word[23:16]] <= word[15:0];
    end
  end

  // Completed words, for software
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      words_r <= '0;
    else if (ce && word_done)
      words_r <= words_r + 16'h0001;
  end

  // Readback shifter, updated after falling edges
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_shift_r      <= '0;
      serial_data_out <= 1'b0;
    end
    else if (ce)
    begin
      if (rb_load)
        rd_shift_r <= regs_r[rb_addr];
      else if (sclk_fall && !sel_s && bitcnt_r >= scpm_pkg::ADDR_DONE)
      begin
        serial_data_out <= rd_shift_r[15];
        rd_shift_r      <= {rd_shift_r[14:0], 1'b0};
      end
    end
  end

  // Driver enable tracks the readback bit only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      serial_data_out_oe <= 1'b0;
    else if (ce)
      serial_data_out_oe <= readback_en;
  end

  // Power state; a single flop stage keeps entry far inside the limit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pwr_state <= '0;
    else if (ce)
    begin
      pwr_state.atten_partial_off  <= fast_s || regs_r[scpm_pkg::REG_ATTEN][scpm_pkg::FAST_PD_BIT];
      pwr_state.conv_partial_off   <= fast_s;
      pwr_state.atten_full_off     <= gbl_s || regs_r[scpm_pkg::REG_ATTEN][scpm_pkg::ATTEN_OFF_BIT];
      pwr_state.conv_full_off      <= gbl_s || regs_r[scpm_pkg::REG_CONV][scpm_pkg::CONV_OFF_BIT];
      pwr_state.refs_on            <= !(gbl_s || regs_r[scpm_pkg::REG_ATTEN][scpm_pkg::ATTEN_OFF_BIT]);
      pwr_state.serializers_on     <= !(gbl_s || regs_r[scpm_pkg::REG_CONV][scpm_pkg::CONV_OFF_BIT]);
      pwr_state.signal_amps_on     <= !(fast_s || gbl_s || regs_r[scpm_pkg::REG_ATTEN][scpm_pkg::FAST_PD_BIT]
                                      || regs_r[scpm_pkg::REG_ATTEN][scpm_pkg::ATTEN_OFF_BIT]);
      pwr_state.atten_amp_off      <= regs_r[scpm_pkg::REG_ATTEN][scpm_pkg::AMP_OFF_BIT];
      pwr_state.continuous_wave_en <= regs_r[scpm_pkg::REG_PATH][scpm_pkg::CW_SELECT_BIT];
      pwr_state.time_gain_en       <= !regs_r[scpm_pkg::REG_ATTEN][scpm_pkg::AMP_OFF_BIT];
      pwr_state.power_mode_field   <= regs_r[scpm_pkg::REG_ATTEN][scpm_pkg::POWER_MODE_LSB +: 2];
    end
  end

  // AXI write address and data, taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      awaddr_r      <= '0;
      wdata_r       <= '0;
      wstrb0_r      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_r      <= 1'b1;
        awaddr_r      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      else if (aw_got_r && w_got_r && !s_axi_bvalid)
        aw_got_r <= 1'b0;
      else
        s_axi_awready <= !aw_got_r && !s_axi_bvalid;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_r      <= 1'b1;
        wdata_r      <= s_axi_wdata;
        wstrb0_r     <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      else if (aw_got_r && w_got_r && !s_axi_bvalid)
        w_got_r <= 1'b0;
      else
        s_axi_wready <= !w_got_r && !s_axi_bvalid;
    end
  end

  // AXI write response and peek address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= scpm_pkg::RESP_OKAY;
      peek_addr_r  <= '0;
    end
    else if (ce)
    begin
      if (aw_got_r && w_got_r && !s_axi_bvalid)
      begin
        s_axi_bvalid <= 1'b1;
        if (awaddr_r == scpm_pkg::AXI_PEEK_ADDR)
        begin
          s_axi_bresp <= scpm_pkg::RESP_OKAY;
          if (wstrb0_r)
            peek_addr_r <= wdata_r[7:0];
        end
        else
          s_axi_bresp <= scpm_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // AXI read; status words show live block state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= scpm_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= scpm_pkg::RESP_OKAY;
        case (s_axi_araddr)
          scpm_pkg::AXI_STATUS:    s_axi_rdata <= {18'h00000, state_r, readback_en, pwr_state};
          scpm_pkg::AXI_WORDS:     s_axi_rdata <= {16'h0000, words_r};
          scpm_pkg::AXI_PEEK_ADDR: s_axi_rdata <= {24'h000000, peek_addr_r};
          scpm_pkg::AXI_PEEK_DATA: s_axi_rdata <= {16'h0000, regs_r[peek_addr_r]};
          default:
          begin
            s_axi_rdata <= '0;
            s_axi_rresp <= scpm_pkg::RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      else
        s_axi_arready <= !s_axi_rvalid;
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  property p_idle_clear;
    sel_s |=> bitcnt_r == 5'h00;
  endproperty
  a_idle_clear: assert property (p_idle_clear) else $error("counter not held while deselected");

  property p_shift_in;
    shift_en |=> shreg_r[0] == $past(serial_data_in_s);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("data bit not shifted in");

  property p_word_write;
    (word_done && !readback_en) |=> regs_r[$past(word[23:16])] == $past(word[15:0]);
  endproperty
  a_word_write: assert property (p_word_write) else $error("word not stored");

  property p_only_full;
    !mem_we |=> regs_r[$past(peek_addr_r)] == $past(regs_r[peek_addr_r]);
  endproperty
  a_only_full: assert property (p_only_full) else $error("write outside 24th edge");

  property p_restart;
    sel_fall |=> bitcnt_r == 5'h00;
  endproperty
  a_restart: assert property (p_restart) else $error("counter not restarted");

  property p_rb_load;
    rb_load |=> rd_shift_r == regs_r[$past(rb_addr)];
  endproperty
  a_rb_load: assert property (p_rb_load) else $error("readback word wrong");

  property p_rb_block;
    (word_done && readback_en && word[23:16] != scpm_pkg::REG_CTRL0)
      |=> regs_r[$past(word[23:16])] == $past(regs_r[word[23:16]]);
  endproperty
  a_rb_block: assert property (p_rb_block) else $error("write taken in readback");

  property p_oe;
    !readback_en |=> !serial_data_out_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("output driven without readback");

  property p_pd_fast;
    $rose(fast_s) |-> ##[1:PD_BOUND] (pwr_state.atten_partial_off && pwr_state.conv_partial_off);
  endproperty
  a_pd_fast: assert property (p_pd_fast) else $error("partial power-down late");

  property p_partial_keep;
    (pwr_state.atten_partial_off && !pwr_state.atten_full_off && !pwr_state.conv_full_off)
      |-> pwr_state.refs_on && pwr_state.serializers_on && !pwr_state.signal_amps_on;
  endproperty
  a_partial_keep: assert property (p_partial_keep) else $error("partial power-down state wrong");

  property p_full_off;
    gbl_s |=> pwr_state.atten_full_off && pwr_state.conv_full_off && !pwr_state.refs_on;
  endproperty
  a_full_off: assert property (p_full_off) else $error("global power-down missed");

  c_word:      cover property (mem_we && !readback_en);
  c_readback:  cover property (rb_load && readback_en);
  c_two_words: cover property (word_done ##[1:1000] (word_done && !sel_s));
  c_partial:   cover property (pwr_state.atten_partial_off && !pwr_state.conv_partial_off);
endmodule

// file: tb/scpm_ctrl_model.sv
// Purpose: Behavioural configuration controller on the serial pins
// Assumes: 400 ns serial clock, paced by aclk edges
// Notes:   Clock idles low, data falls to its pull-down between frames
`timescale 1ns/1ps
module scpm_ctrl_model (
  // Pacing clock
  input  wire logic        aclk,
  // Serial pins
  output logic             serial_select_n,
  output logic             serial_clk,
  output logic             serial_data_in,
  input  wire logic        sdo_line,
  // Bits seen on the readback line
  output logic [23:0]      rx
);
  initial
  begin
    serial_select_n = 1'b1;
    serial_clk      = 1'b0;
    serial_data_in  = 1'b0;
    rx              = 24'h000000;
  end

  task automatic half_period();
    repeat (4) @(posedge aclk);
  endtask

  // Sends v[n-1:0], top bit first; bits of v above n-1 are not sent
  task automatic xfer(input logic [47:0] v, input int n);
    @(posedge aclk);
    serial_select_n <= 1'b0;
    half_period();
    for (int i = n - 1; i >= 0; i--)
    begin
      serial_data_in <= v[i];
      half_period();
      // Slow clock, so the rising edge is a safe capture point
      rx         <= {rx[22:0], sdo_line};
      serial_clk <= 1'b1;
      half_period();
      serial_clk <= 1'b0;
    end
    half_period();
    serial_select_n <= 1'b1;
    serial_data_in  <= 1'b0;
  endtask
endmodule

// file: tb/tb.sv
// Purpose: Self-checking bench for the serial config port
// Assumes: 20 MHz aclk, controller model on the serial pins
// Notes:   Register contents are seen through the AXI peek window
`timescale 1ns/1ps
module tb;
  // Clock, reset and pins
  logic                aclk;
  logic                ce;
  logic                aresetn;
  logic                serial_select_n;
  logic                serial_clk;
  logic                serial_data_in;
  logic                serial_data_out;
  logic                serial_data_out_oe;
  logic                fast_powerdown_pin;
  logic                global_powerdown_pin;
  scpm_pkg::scpm_pwr_t pwr_state;
  logic [23:0]         rx;
  // No pull-up on the readback line
  wire                 sdo_line = serial_data_out_oe ? serial_data_out : !serial_data_out;
  // AXI4-Lite
  logic [7:0]          s_axi_awaddr;
  logic                s_axi_awvalid;
  logic                s_axi_awready;
  logic [31:0]         s_axi_wdata;
  logic [3:0]          s_axi_wstrb;
  logic                s_axi_wvalid;
  logic                s_axi_wready;
  logic [1:0]          s_axi_bresp;
  logic                s_axi_bvalid;
  logic                s_axi_bready;
  logic [7:0]          s_axi_araddr;
  logic                s_axi_arvalid;
  logic                s_axi_arready;
  logic [31:0]         s_axi_rdata;
  logic [1:0]          s_axi_rresp;
  logic                s_axi_rvalid;
  logic                s_axi_rready;
  int                  n_errors = 0;
  int                  n_checks = 0;
  int                  n_words  = 0;

  scpm_port i_dut (
    .aclk, .ce, .aresetn, .serial_select_n, .serial_clk, .serial_data_in,
    .serial_data_out, .serial_data_out_oe, .fast_powerdown_pin, .global_powerdown_pin,
    .pwr_state, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  scpm_ctrl_model i_ctl (
    .aclk, .serial_select_n, .serial_clk, .serial_data_in, .sdo_line, .rx
  );

  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic fail_timeout();
    n_errors++;
    $display("mismatch at %0t: wait ran out", $time);
    report_and_stop();
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] pw(input logic [11:0] m);
    return {20'h0, 12'(pwr_state) & m};
  endfunction

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (int k = 0; k < 100; k++)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        return;
      end
    end
    fail_timeout();
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (int k = 0; k < 100; k++)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        return;
      end
    end
    fail_timeout();
  endtask

  task automatic peek(input logic [7:0] a, input logic [15:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(scpm_pkg::AXI_PEEK_ADDR, {24'h0, a}, r);
    axi_rd(scpm_pkg::AXI_PEEK_DATA, d, r);
    check(d, {16'h0, e});
  endtask

  task automatic sw(input logic [23:0] w);
    i_ctl.xfer({24'h0, w}, 24);
    n_words++;
  endtask

  // Power-down requests must land within the deadline
  task automatic settle(input logic [11:0] m, input logic [11:0] e);
    for (int k = 0; k < scpm_pkg::PD_LIMIT_CYC; k++)
    begin
      @(posedge aclk);
      if ((12'(pwr_state) & m) === e)
        return;
    end
    fail_timeout();
  endtask

  task automatic t_power();
    @(posedge aclk);
    fast_powerdown_pin <= 1'b1;
    settle(12'h800, 12'h800);
    check(pw(12'hce0), 32'hcc0);
    @(posedge aclk);
    fast_powerdown_pin <= 1'b0;
    settle(12'hc00, 12'h000);
    repeat (1000) @(posedge aclk);
    sw({scpm_pkg::REG_ATTEN, 16'h4000});
    check(pw(12'hc00), 32'h800);
    sw({scpm_pkg::REG_ATTEN, 16'h0000});
    @(posedge aclk);
    global_powerdown_pin <= 1'b1;
    settle(12'h300, 12'h300);
    check(pw(12'h380), 32'h300);
    @(posedge aclk);
    global_powerdown_pin <= 1'b0;
    settle(12'h300, 12'h000);
    sw({scpm_pkg::REG_ATTEN, 16'h8000});
    check(pw(12'h300), 32'h200);
    sw({scpm_pkg::REG_CONV, 16'h0001});
    check(pw(12'h300), 32'h300);
    sw({scpm_pkg::REG_ATTEN, 16'h0000});
  endtask

  task automatic t_words();
    logic [31:0] d;
    logic [1:0]  r;
    sw({scpm_pkg::REG_ATTEN, 16'h1800});
    check(pw(12'h017), 32'h012);
    peek(scpm_pkg::REG_ATTEN, 16'h1800);
    i_ctl.xfer({scpm_pkg::REG_PATH, 16'h0200, scpm_pkg::REG_CONV, 16'h0000}, 48);
    n_words += 2;
    check(pw(12'h108), 32'h008);
    // Second word cut one bit short must be dropped
    i_ctl.xfer({1'b0, scpm_pkg::REG_CONV, 16'h0001, 23'h628000}, 47);
    n_words++;
    check(pw(12'h100), 32'h100);
    peek(scpm_pkg::REG_ATTEN, 16'h1800);
    sw({scpm_pkg::REG_CONV, 16'h0000});
    check(pw(12'h100), 32'h000);
    axi_rd(scpm_pkg::AXI_WORDS, d, r);
    check(d, 32'(n_words));
  endtask

  task automatic t_readback();
    check(32'(serial_data_out_oe), 32'h0);
    sw({scpm_pkg::REG_CTRL0, 16'h0002});
    check(32'(serial_data_out_oe), 32'h1);
    sw({scpm_pkg::REG_ATTEN, 16'h0400});
    check(pw(12'h003), 32'h002);
    sw({scpm_pkg::REG_PATH, 16'h0000});
    check({8'h0, rx}, 32'h0200);
    sw({scpm_pkg::REG_CTRL0, 16'h0000});
    check(32'(serial_data_out_oe), 32'h0);
    sw({scpm_pkg::REG_ATTEN, 16'h0400});
    check(pw(12'h017), 32'h005);
  endtask

  task automatic t_axi();
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(scpm_pkg::AXI_WORDS, 32'h0000ffff, r);
    check(32'(r), 32'(scpm_pkg::RESP_SLVERR));
    axi_rd(8'h10, d, r);
    check(32'(r), 32'(scpm_pkg::RESP_SLVERR));
    check(d, 32'h0);
    // Enable low must freeze the pin path
    @(posedge aclk);
    ce                 <= 1'b0;
    fast_powerdown_pin <= 1'b1;
    repeat (10) @(posedge aclk);
    check(pw(12'h800), 32'h000);
    ce <= 1'b1;
    settle(12'h800, 12'h800);
    fast_powerdown_pin <= 1'b0;
    settle(12'h800, 12'h000);
    axi_rd(scpm_pkg::AXI_STATUS, d, r);
    check(d, 32'h0ed);
  endtask

  initial
  begin
    ce                   = 1'b1;
    aresetn              = 1'b0;
    fast_powerdown_pin   = 1'b0;
    global_powerdown_pin = 1'b0;
    s_axi_awaddr         = 8'h00;
    s_axi_awvalid        = 1'b0;
    s_axi_wdata          = 32'h0;
    s_axi_wstrb          = 4'hf;
    s_axi_wvalid         = 1'b0;
    s_axi_bready         = 1'b0;
    s_axi_araddr         = 8'h00;
    s_axi_arvalid        = 1'b0;
    s_axi_rready         = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    check(pw(12'hfff), 32'h0e4);
    sw({scpm_pkg::REG_CONV, 16'h0014});
    peek(scpm_pkg::REG_CONV, 16'h0014);
    t_power();
    t_words();
    t_readback();
    t_axi();
    report_and_stop();
  end
endmodule
